// ==== fpk_device_end.sv ====
`timescale 1ns/100ps
module fpk_device_end (
    fpk_panel_if.device bus,
    input wire logic [fpk_pkg::NUM_ROW*fpk_pkg::NUM_COL-1:0] keyDown,
    input wire logic preset_key_n,
    input wire logic encClk,
    input wire logic encUpDn,
    output logic [fpk_pkg::NUM_SEL-1:0] frontSelect,
    output logic [fpk_pkg::NUM_COL-1:0] columnStrobe,
    output logic [fpk_pkg::NUM_ROW-1:0] rowSense,
    output logic [fpk_pkg::NUM_LAMP-1:0] lampOn,
    output logic [fpk_pkg::KNOB_W-1:0] knobCount
);
    import fpk_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Panel state: one packed struct, registered in one place.
    typedef struct packed {
        // Registered outputs and the read answer.
        logic [NUM_SEL-1:0] sel;
        logic [NUM_COL-1:0] col;
        logic [NUM_ROW-1:0] rows;
        logic [NUM_LAMP-1:0] lamp;
        logic [DATA_W-1:0] rdData;

        // Two-stage synchronisers for the pins.
        logic [NUM_ROW*NUM_COL-1:0] keyS1;
        logic [NUM_ROW*NUM_COL-1:0] keyS2;
        logic presetS1;
        logic presetS2;
    } fpk_dev_s;

    // Lamps come out of reset all on, which is what the preset key shows.
    localparam fpk_dev_s DEV_RESET = '{
        sel: '0,
        col: COL_RESET,
        rows: '0,
        lamp: LAMP_ALL_ON,
        rdData: '0,
        keyS1: '0,
        keyS2: '0,
        presetS1: 1'b1,
        presetS2: 1'b1
    };

    // Present and next panel state.
    fpk_dev_s q;
    fpk_dev_s next_q;

    // Helpers, recomputed every cycle.
    logic access;
    logic isWrite;
    logic isRead;
    logic [NUM_ROW-1:0] rowHit;
    logic [NUM_LAMP-1:0] lampDecode;
    logic [KNOB_W-1:0] knobValue;

    ////////////////////////////////////////////////////////////////////////
    // Access qualification. The strobe comes from host flops on this
    // clock, so it is used without a synchroniser.
    // Decode is full: an address with no latch behind it still
    // raises its select, which the cycle test relies on.
    assign access = !bus.io_access_strobe_n;
    assign isWrite = access && !bus.writeN;
    assign isRead = access && bus.writeN;

    ////////////////////////////////////////////////////////////////////////
    // Key matrix: a closed key ties its row to its column line. Only the
    // second stage of the key synchroniser feeds the matrix, so a bouncing
    // contact never reaches the row outputs half-resolved.
    generate
        for (genvar r = 0; r < NUM_ROW; r++) begin : gRow
            // One OR term per row over all of its columns.
            assign rowHit[r] = |(q.keyS2[r*NUM_COL +: NUM_COL] & q.col);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Lamp index decode. An index past the last lamp turns all lamps off,
    // so a sequence test that overruns shows up as a dark panel.
    // The index is binary, in the low nibble of the data.
    always_comb begin
        if (bus.wrData[3:0] < 4'(NUM_LAMP)) begin
            lampDecode = LAMP_ONE << bus.wrData[3:0];
        end else begin
            lampDecode = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Knob counter with its own pin synchronisers. The clear line comes
    // from host flops on the same clock and goes straight in.
    // Clear beats a knob edge in the same cycle, so a detent that
    // lands during the clear is lost, not counted afterwards.
    fpk_knob_counter uKnob (
        .clk(bus.clk),
        .resetn(bus.resetn),
        .encClk(encClk),
        .encUpDn(encUpDn),
        .clearN(bus.knob_count_clear_n),
        .count(knobValue)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state of the panel logic.
    always_comb begin
        // Every field holds unless a branch below changes it.
        next_q = q;

        // Pin synchronisers for the key matrix and the preset key.
        next_q.keyS1 = keyDown;
        next_q.keyS2 = q.keyS1;
        next_q.presetS1 = preset_key_n;
        next_q.presetS2 = q.presetS1;

        // Row sense follows the column latch through the matrix.
        // A row read therefore lags its column write by one cycle.
        next_q.rows = rowHit;

        // One-hot select, only while the strobe is low. The select lags
        // the strobe by one cycle because every output leaves a flop.
        // It drops one cycle after the strobe rises, never before.
        if (access) begin
            next_q.sel = SEL_ONE << bus.addr;
        end else begin
            next_q.sel = '0;
        end

        // Writes. They repeat on every strobe cycle; that is harmless
        // since the host holds address and data for the whole access.
        if (isWrite) begin
            unique case (bus.addr)
                ADDR_COLUMN: begin
                    next_q.col = bus.wrData[NUM_COL-1:0];
                end
                ADDR_LAMP: begin
                    next_q.lamp = lampDecode;
                end
                default: begin
                    // Rows and knob are read only; the rest only select.
                end
            endcase
        end

        // Holding the preset key overrides whatever the host last wrote.
        // Only the synchronised level is used, so a bouncing key can
        // flicker the lamps but never feed a half-settled level in.
        if (!q.presetS2) begin
            next_q.lamp = LAMP_ALL_ON;
        end

        // Read data. The knob count is only sampled, never changed.
        next_q.rdData = '0;

        if (isRead) begin
            unique case (bus.addr)
                ADDR_COLUMN: begin
                    next_q.rdData = DATA_W'(q.col);
                end
                ADDR_ROWS: begin
                    next_q.rdData = DATA_W'(q.rows);
                end
                ADDR_LAMP: begin
                    next_q.rdData = DATA_W'(q.lamp);
                end
                ADDR_KNOB: begin
                    next_q.rdData = DATA_W'(knobValue);
                end
                default: begin
                    next_q.rdData = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register. Reset lights every lamp and parks the columns low.
    // The lamp reset value stands in for the preset key during reset.
    always_ff @(posedge bus.clk or negedge bus.resetn) begin
        if (!bus.resetn) begin
            q <= DEV_RESET;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops.
    // The knob count leaves the counter's own flop, so it needs no
    // second stage here.
    assign bus.rdData = q.rdData;
    assign frontSelect = q.sel;
    assign columnStrobe = q.col;
    assign rowSense = q.rows;
    assign lampOn = q.lamp;
    assign knobCount = knobValue;

endmodule : fpk_device_end

// ==== fpk_host_end.sv ====
`timescale 1ns/100ps
module fpk_host_end #(
    parameter int unsigned COL_HOLD_CYCLES = fpk_pkg::COL_PULSE_CYCLES,
    parameter int unsigned LAMP_HOLD_CYCLES = fpk_pkg::LAMP_HOLD_DEFAULT
) (
    fpk_panel_if.host bus,
    input wire logic run,
    input wire fpk_pkg::fpk_mode_e mode,
    output logic [fpk_pkg::DATA_W-1:0] rdLast,
    output logic [fpk_pkg::ADDR_W-1:0] rdAddrLast,
    output logic rdValid
);
    import fpk_pkg::*;

    typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_STROBE} fpk_hstate_e;

    typedef struct packed {
        fpk_hstate_e state;
        fpk_mode_e curMode;
        logic [STEP_W-1:0] step;
        logic [WAIT_W-1:0] cnt;
        logic knobCleared;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic writeN;
        logic strobeN;
        logic clearN;
        logic [DATA_W-1:0] rdLast;
        logic [ADDR_W-1:0] rdAddrLast;
        logic rdValid;
    } fpk_host_s;

    localparam fpk_host_s HOST_RESET = '{
        state: HS_IDLE, curMode: FPK_KEY_SCAN, step: '0, cnt: '0,
        knobCleared: 1'b0, addr: '0, wrData: '0, writeN: 1'b1,
        strobeN: 1'b1, clearN: 1'b1, rdLast: '0, rdAddrLast: '0,
        rdValid: 1'b0};

    fpk_host_s q;
    fpk_host_s next_q;
    logic opWrite;
    logic [ADDR_W-1:0] opAddr;
    logic [DATA_W-1:0] opData;
    logic [WAIT_W-1:0] opWait;
    logic [STEP_W-1:0] lastStep;

    ////////////////////////////////////////////////////////////////////////
    // The access that the current step of each mode makes.
    always_comb begin
        opWrite = 1'b0;
        opAddr = ADDR_KNOB;
        opData = '0;
        opWait = WAIT_W'(GAP_CYCLES);
        lastStep = '0;
        unique case (q.curMode)
            FPK_KEY_SCAN: begin
                // Even steps move the single one to the next column, odd
                // steps sample the rows just before it moves on.
                opWrite = !q.step[0];
                opAddr = q.step[0] ? ADDR_ROWS : ADDR_COLUMN;
                opData = WALK_ONE << q.step[STEP_W-1:1];
                opWait = q.step[0] ? WAIT_W'(GAP_CYCLES) : WAIT_W'(COL_HOLD_CYCLES);
                lastStep = STEP_W'(2 * NUM_COL - 1);
            end
            FPK_DECODE_CYCLE: begin
                opAddr = q.step[ADDR_W-1:0];
                lastStep = STEP_W'(NUM_SEL - 1);
            end
            FPK_LAMP_SEQUENCE_TEST: begin
                opWrite = 1'b1;
                opAddr = ADDR_LAMP;
                opData = DATA_W'(q.step);
                opWait = WAIT_W'(LAMP_HOLD_CYCLES);
                lastStep = STEP_W'(NUM_LAMP - 1);
            end
            FPK_KNOB_READ_TEST: begin
                opAddr = ADDR_KNOB;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: each access holds the strobe low for a fixed length with
    // address and data stable across it.
    always_comb begin
        next_q = q;
        next_q.rdValid = 1'b0;
        unique case (q.state)
            HS_IDLE: begin
                if (run) begin
                    next_q.curMode = mode;
                    next_q.step = '0;
                    next_q.knobCleared = 1'b0;
                    next_q.cnt = '0;
                    next_q.state = HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (q.cnt != '0) begin
                    next_q.cnt = q.cnt - WAIT_ONE;
                end else if (!run || mode != q.curMode) begin
                    next_q.state = HS_IDLE;
                end else begin
                    next_q.addr = opAddr;
                    next_q.wrData = opData;
                    next_q.writeN = !opWrite;
                    next_q.strobeN = 1'b0;
                    // The knob count is cleared on the first read only.
                    if (q.curMode == FPK_KNOB_READ_TEST && !q.knobCleared) begin
                        next_q.clearN = 1'b0;
                        next_q.knobCleared = 1'b1;
                    end
                    next_q.cnt = WAIT_W'(STROBE_CYCLES - 1);
                    next_q.state = HS_STROBE;
                end
            end
            HS_STROBE: begin
                if (q.cnt != '0) begin
                    next_q.cnt = q.cnt - WAIT_ONE;
                end else begin
                    next_q.strobeN = 1'b1;
                    next_q.clearN = 1'b1;
                    if (q.writeN) begin
                        next_q.rdLast = bus.rdData;
                        next_q.rdAddrLast = q.addr;
                        next_q.rdValid = 1'b1;
                    end
                    next_q.cnt = opWait;
                    next_q.step = (q.step == lastStep) ? '0 : q.step + STEP_ONE;
                    next_q.state = HS_WAIT;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge bus.clk or negedge bus.resetn) begin
        if (!bus.resetn) begin
            q <= HOST_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign bus.addr = q.addr;
    assign bus.wrData = q.wrData;
    assign bus.writeN = q.writeN;
    assign bus.io_access_strobe_n = q.strobeN;
    assign bus.knob_count_clear_n = q.clearN;
    assign rdLast = q.rdLast;
    assign rdAddrLast = q.rdAddrLast;
    assign rdValid = q.rdValid;

endmodule : fpk_host_end

// ==== fpk_knob_counter.sv ====
`timescale 1ns/100ps
module fpk_knob_counter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic encClk,
    input wire logic encUpDn,
    input wire logic clearN,
    output logic [fpk_pkg::KNOB_W-1:0] count
);
    import fpk_pkg::*;

    typedef struct packed {
        logic clkS1;
        logic clkS2;
        logic clkPrev;
        logic dirS1;
        logic dirS2;
        logic [KNOB_W-1:0] count;
    } fpk_knob_s;

    fpk_knob_s q;
    fpk_knob_s next_q;

    ////////////////////////////////////////////////////////////////////////
    // Both knob lines get the same two-stage latency, so direction is
    // already settled when the clock edge is seen.
    always_comb begin
        next_q = q;
        next_q.clkS1 = encClk;
        next_q.clkS2 = q.clkS1;
        next_q.clkPrev = q.clkS2;
        next_q.dirS1 = encUpDn;
        next_q.dirS2 = q.dirS1;
        if (!clearN) begin
            next_q.count = KNOB_CLEAR_VALUE;
        end else if (q.clkS2 && !q.clkPrev) begin
            // High direction line means clockwise.
            next_q.count = q.dirS2 ? q.count + KNOB_ONE : q.count - KNOB_ONE;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign count = q.count;

endmodule : fpk_knob_counter

// ==== fpk_panel_chk.sv ====
`timescale 1ns/100ps
module fpk_panel_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [fpk_pkg::ADDR_W-1:0] addr,
    input wire logic [fpk_pkg::DATA_W-1:0] wrData,
    input wire logic writeN,
    input wire logic io_access_strobe_n,
    input wire logic knob_count_clear_n,
    input wire logic [fpk_pkg::DATA_W-1:0] rdData
);
    import fpk_pkg::*;

    // Every check samples on the rising edge and sleeps through reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////
    // An access strobe stands exactly three cycles.
    property p_strobe_len;
        $fell(io_access_strobe_n) |->
            ##1 !io_access_strobe_n ##1 !io_access_strobe_n ##1 io_access_strobe_n;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");

    // Address, data and direction hold still while the strobe is low.
    property p_qual_stable;
        (!io_access_strobe_n && !$past(io_access_strobe_n)) |->
            ($stable(addr) && $stable(wrData) && $stable(writeN));
    endproperty
    a_qual_stable: assert property (p_qual_stable) else $error("qualifiers moved");

    // At least three idle cycles separate two accesses.
    property p_gap;
        $rose(io_access_strobe_n) |-> io_access_strobe_n[*3];
    endproperty
    a_gap: assert property (p_gap) else $error("access gap too short");

    // Read data is zero unless a strobe was seen on the edge before.
    property p_rd_idle;
        $past(io_access_strobe_n) |-> (rdData == '0);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside access");

    // The knob clear only accompanies a read of the knob address.
    property p_clear_at_knob;
        !knob_count_clear_n |-> (!io_access_strobe_n && addr == ADDR_KNOB && writeN);
    endproperty
    a_clear_at_knob: assert property (p_clear_at_knob) else $error("clear off knob read");

    // The clear is one three-cycle level, never a longer hold.
    property p_clear_len;
        $fell(knob_count_clear_n) |->
            ##1 !knob_count_clear_n ##1 !knob_count_clear_n ##1 knob_count_clear_n;
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear length wrong");

    // A column write carries a single one.
    property p_col_onehot;
        (!io_access_strobe_n && !writeN && addr == ADDR_COLUMN) |->
            $onehot(wrData[NUM_COL-1:0]);
    endproperty
    a_col_onehot: assert property (p_col_onehot) else $error("column not one-hot");

    // A lamp write names an existing lamp; indices 12 to 15 would blank the panel.
    property p_lamp_index;
        (!io_access_strobe_n && !writeN && addr == ADDR_LAMP) |-> (int'(wrData) < NUM_LAMP);
    endproperty
    a_lamp_index: assert property (p_lamp_index) else $error("lamp index out of range");

    // Main traffic kinds seen at least once.
    c_knob_read: cover property (!knob_count_clear_n);
    c_col_write: cover property (!io_access_strobe_n && !writeN && addr == ADDR_COLUMN);
    c_lamp_write: cover property (!io_access_strobe_n && !writeN && addr == ADDR_LAMP);
endmodule : fpk_panel_chk

// ==== fpk_panel_if.sv ====
`timescale 1ns/100ps
// Parallel front-panel bus between host and panel logic.
interface fpk_panel_if (
    input wire logic clk,
    input wire logic resetn
);
    logic [fpk_pkg::ADDR_W-1:0] addr;
    logic [fpk_pkg::DATA_W-1:0] wrData;
    logic writeN;
    logic io_access_strobe_n;
    logic knob_count_clear_n;
    logic [fpk_pkg::DATA_W-1:0] rdData;

    modport device (
        input clk,
        input resetn,
        input addr,
        input wrData,
        input writeN,
        input io_access_strobe_n,
        input knob_count_clear_n,
        output rdData
    );

    modport host (
        input clk,
        input resetn,
        input rdData,
        output addr,
        output wrData,
        output writeN,
        output io_access_strobe_n,
        output knob_count_clear_n
    );
endinterface : fpk_panel_if

// ==== fpk_pkg.sv ====
package fpk_pkg;

    // Bus and panel geometry.
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int NUM_SEL = 8;
    localparam int NUM_COL = 8;
    localparam int NUM_ROW = 8;
    localparam int NUM_FRONT_LAMP = 4;
    localparam int NUM_CPU_LAMP = 8;
    localparam int NUM_LAMP = NUM_FRONT_LAMP + NUM_CPU_LAMP;
    localparam int KNOB_W = 16;
    localparam int STEP_W = 4;
    localparam int WAIT_W = 20;

    // Decoded front-panel addresses; the remaining ones select only.
    localparam logic [ADDR_W-1:0] ADDR_COLUMN = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_ROWS = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_LAMP = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_KNOB = 3'h3;

    // Reset and constant values.
    localparam logic [KNOB_W-1:0] KNOB_CLEAR_VALUE = 16'h0000;
    localparam logic [KNOB_W-1:0] KNOB_ONE = 16'h0001;
    localparam logic [NUM_LAMP-1:0] LAMP_ALL_ON = 12'hFFF;
    localparam logic [NUM_LAMP-1:0] LAMP_ONE = 12'h001;
    localparam logic [NUM_SEL-1:0] SEL_ONE = 8'h01;
    localparam logic [NUM_COL-1:0] COL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] WALK_ONE = 16'h0001;
    localparam logic [STEP_W-1:0] STEP_ONE = 4'h1;
    localparam logic [WAIT_W-1:0] WAIT_ONE = 20'h00001;

    // Timing: one column is strobed for the row pulse width.
    localparam int CLK_HZ = 100_000_000;
    localparam int COL_PULSE_MS = 7;
    localparam int COL_PULSE_CYCLES = COL_PULSE_MS * (CLK_HZ / 1000);
    localparam int LAMP_HOLD_DEFAULT = 1000;
    localparam int STROBE_CYCLES = 3;
    localparam int GAP_CYCLES = 2;

    typedef enum logic [1:0] {
        FPK_KEY_SCAN,
        FPK_DECODE_CYCLE,
        FPK_LAMP_SEQUENCE_TEST,
        FPK_KNOB_READ_TEST
    } fpk_mode_e;

endpackage : fpk_pkg

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import fpk_pkg::*;
    localparam int unsigned COL_HOLD = 20;
    localparam int unsigned LAMP_HOLD = 10;
    localparam int TIMEOUT_CYCLES = 20000;
    logic clk;
    logic resetn;
    logic run;
    fpk_mode_e mode;
    logic [NUM_ROW*NUM_COL-1:0] keyDown;
    logic presetKeyN;
    logic encClk;
    logic encUpDn;
    logic [DATA_W-1:0] rdLast;
    logic [ADDR_W-1:0] rdAddrLast;
    logic rdValid;
    logic [NUM_SEL-1:0] frontSelect;
    logic [NUM_COL-1:0] columnStrobe;
    logic [NUM_ROW-1:0] rowSense;
    logic [NUM_LAMP-1:0] lampOn;
    logic [KNOB_W-1:0] knobCount;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Host and device face each other; the checker watches the bus between.
    fpk_panel_if i_fpk_panel_if (.clk(clk), .resetn(resetn));
    fpk_host_end #(.COL_HOLD_CYCLES(COL_HOLD), .LAMP_HOLD_CYCLES(LAMP_HOLD)) i_fpk_host_end (
        .bus(i_fpk_panel_if.host), .run(run), .mode(mode), .rdLast(rdLast),
        .rdAddrLast(rdAddrLast), .rdValid(rdValid));
    fpk_device_end i_fpk_device_end (
        .bus(i_fpk_panel_if.device), .keyDown(keyDown), .preset_key_n(presetKeyN),
        .encClk(encClk), .encUpDn(encUpDn), .frontSelect(frontSelect),
        .columnStrobe(columnStrobe), .rowSense(rowSense), .lampOn(lampOn),
        .knobCount(knobCount));
    fpk_panel_chk i_fpk_panel_chk (
        .clk(clk), .resetn(resetn), .addr(i_fpk_panel_if.addr),
        .wrData(i_fpk_panel_if.wrData), .writeN(i_fpk_panel_if.writeN),
        .io_access_strobe_n(i_fpk_panel_if.io_access_strobe_n),
        .knob_count_clear_n(i_fpk_panel_if.knob_count_clear_n),
        .rdData(i_fpk_panel_if.rdData));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // A hang is cut short and counted as a mismatch.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // A mode change sends the host back to idle before it starts again.
    task automatic start_mode(input fpk_mode_e m);
        @(negedge clk);
        mode = m;
        run = 1'b1;
    endtask : start_mode

    // One knob detent, held long enough to pass the input synchroniser.
    task automatic enc_pulse(input logic up);
        @(negedge clk);
        encUpDn = up;
        repeat (2) @(negedge clk);
        encClk = 1'b1;
        repeat (4) @(negedge clk);
        encClk = 1'b0;
        repeat (4) @(negedge clk);
    endtask : enc_pulse

    task automatic wait_read(input logic [ADDR_W-1:0] a);
        for (int i = 0; i < 200; i++) begin
            @(negedge clk);
            if (rdValid === 1'b1 && rdAddrLast === a) break;
        end
    endtask : wait_read

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(lampOn, LAMP_ALL_ON);
        check(frontSelect, 0);
        check(columnStrobe, COL_RESET);
        check(knobCount, KNOB_CLEAR_VALUE);
        $display("t_reset done");
    endtask : t_reset

    // Selects lag the strobe by one cycle, so compare with last cycle's bus.
    task automatic t_decode;
        logic [NUM_SEL-1:0] seen;
        logic prevStrobeN;
        logic [ADDR_W-1:0] prevAddr;
        int bad;
        seen = '0;
        bad = 0;
        prevStrobeN = 1'b1;
        prevAddr = '0;
        start_mode(FPK_DECODE_CYCLE);
        for (int i = 0; i < 400 && seen != 8'hFF; i++) begin
            @(negedge clk);
            if (frontSelect != '0 && (frontSelect !== SEL_ONE << prevAddr || prevStrobeN)) bad++;
            seen |= frontSelect;
            prevStrobeN = i_fpk_panel_if.io_access_strobe_n;
            prevAddr = i_fpk_panel_if.addr;
        end
        check(seen, 8'hFF);
        check(bad, 0);
        $display("t_decode done");
    endtask : t_decode

    // The clear must land once on entry and not again while reads go on.
    task automatic t_knob;
        int clears;
        clears = 0;
        for (int i = 0; i < 3; i++) enc_pulse(1'b1);
        check(knobCount, 16'h0003);
        enc_pulse(1'b0);
        check(knobCount, 16'h0002);
        start_mode(FPK_KNOB_READ_TEST);
        for (int i = 0; i < 100 && i_fpk_panel_if.knob_count_clear_n !== 1'b0; i++) @(negedge clk);
        repeat (4) @(negedge clk);
        check(knobCount, KNOB_CLEAR_VALUE);
        fork
            begin
                for (int i = 0; i < 5; i++) enc_pulse(1'b1);
                enc_pulse(1'b0);
            end
            repeat (70) begin
                @(negedge clk);
                if (i_fpk_panel_if.knob_count_clear_n !== 1'b1) clears++;
            end
        join
        check(clears, 0);
        check(knobCount, 16'h0004);
        wait_read(ADDR_KNOB);
        wait_read(ADDR_KNOB);
        check(rdLast, 16'h0004);
        check(knobCount, 16'h0004);
        $display("t_knob done");
    endtask : t_knob

    // One key at row 2, column 5; its row must echo that column a cycle late.
    task automatic t_scan;
        logic [NUM_COL-1:0] prevCol;
        logic [NUM_COL-1:0] expCol;
        int bad;
        int steps;
        int width;
        int minWidth;
        bad = 0;
        steps = 0;
        width = 0;
        minWidth = 1000000;
        expCol = 8'h01;
        keyDown = '0;
        keyDown[21] = 1'b1;
        start_mode(FPK_KEY_SCAN);
        prevCol = columnStrobe;
        for (int i = 0; i < 3000 && steps < 9; i++) begin
            @(negedge clk);
            if (rowSense !== (prevCol[5] ? 8'h04 : 8'h00)) bad++;
            if (rdValid === 1'b1 && rdAddrLast === ADDR_ROWS &&
                rdLast !== (columnStrobe[5] ? 16'h0004 : 16'h0000)) bad++;
            if (rowSense[2] === 1'b1) width++;
            else if (width > 0) begin
                if (width < minWidth) minWidth = width;
                width = 0;
            end
            if (columnStrobe !== prevCol) begin
                if (columnStrobe !== expCol) bad++;
                expCol = {expCol[NUM_COL-2:0], expCol[NUM_COL-1]};
                steps++;
            end
            prevCol = columnStrobe;
        end
        check(steps, 9);
        check(bad, 0);
        check(minWidth >= COL_HOLD, 1);
        keyDown = '0;
        $display("t_scan done");
    endtask : t_scan

    task automatic t_lamp;
        logic [NUM_LAMP-1:0] prev;
        int k;
        int bad;
        k = 0;
        bad = 0;
        start_mode(FPK_LAMP_SEQUENCE_TEST);
        prev = lampOn;
        for (int i = 0; i < 1000 && k < NUM_LAMP; i++) begin
            @(negedge clk);
            if (lampOn !== prev) begin
                if (lampOn !== LAMP_ONE << k) bad++;
                k++;
                prev = lampOn;
            end
        end
        check(k, NUM_LAMP);
        check(bad, 0);
        $display("t_lamp done");
    endtask : t_lamp

    // Holding preset out of reset must still force every lamp on.
    task automatic t_preset;
        run = 1'b0;
        presetKeyN = 1'b0;
        repeat (4) @(negedge clk);
        check(lampOn, LAMP_ALL_ON);
        presetKeyN = 1'b1;
        $display("t_preset done");
    endtask : t_preset

    ////////////////////////////////////////////////////////////////////////////
    // Reset with preset held, then the scenarios in turn.
    initial begin
        resetn = 1'b0;
        run = 1'b0;
        mode = FPK_KEY_SCAN;
        keyDown = '0;
        presetKeyN = 1'b0;
        encClk = 1'b0;
        encUpDn = 1'b1;
        repeat (12) @(negedge clk);
        t_reset();
        resetn = 1'b1;
        presetKeyN = 1'b1;
        t_decode();
        t_knob();
        t_scan();
        t_lamp();
        t_preset();
        report_and_stop();
    end
endmodule : testbench
